// [hw/fcbp_top.sv]
// four-channel double-buffered pwm with apb register access and shared port pins
//
// The address map and the APB interface to the registers were chosen for this implementation.
`include "fcbp_map.svh"

module fcbp_top
  import fcbp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PRES_W = 7
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        port_in,
  output fcbp_pins_t             port_drive
);

  fcbp_ctrl_t   ctrl;
  fcbp_clksel_t clksel;
  logic [7:0]   scale      [2];
  logic [7:0]   scale_cnt  [2];
  logic [1:0]   scale_half;
  logic [PRES_W-1:0] pres;
  logic [1:0]   ab_tick;
  logic [1:0]   s_tick;
  logic [3:0]   ch_tick;
  logic [3:0]   gpio_out;
  logic [3:0]   gpio_dir;

  logic [7:0]   cnt        [4];
  logic [7:0]   per_buf    [4];
  logic [7:0]   per_act    [4];
  logic [7:0]   duty_buf   [4];
  logic [7:0]   duty_act   [4];
  logic [3:0]   count_up;
  logic [3:0]   armed;
  logic [7:0]   next_cnt   [4];
  logic [7:0]   next_per   [4];
  logic [7:0]   next_duty  [4];
  logic [3:0]   next_up;
  logic [3:0]   next_armed;
  logic [3:0]   load_act;
  logic [3:0]   pin_own;
  logic [3:0]   pin_wave;

  logic [3:0]   wr_cnt;
  logic [3:0]   wr_per;
  logic [3:0]   wr_duty;
  logic         wr;
  logic         setup;
  logic [31:0]  next_rdata;
  logic         next_hit;
  logic         hit_q;

  // true when an address selects a register of channel i in a block
  function automatic logic fcbp_hit(input logic [ADDR_W-1:0] a, input logic [7:0] base, input int i);
    logic [7:0] off;
    off = base + 8'(i * 4);
    return a[7:0] == off;
  endfunction

  // one counter step: {next direction, rollover, next count}
  function automatic logic [17:0] fcbp_step(input logic [15:0] c, input logic [15:0] p,
                                            input logic center, input logic up);
    logic [15:0] n;
    logic        nu;
    logic        roll;
    n    = c + 16'h0001;
    nu   = up;
    roll = 1'b0;
    if (!center) begin
      if (({1'b0, c} + 17'h00001) >= {1'b0, p}) begin
        n    = 16'h0000;
        roll = 1'b1;
      end
    end else if (up) begin
      if (c >= p) begin
        nu = 1'b0;
        n  = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
      end
    end else begin
      if (c == 16'h0000) begin
        nu   = 1'b1;
        roll = 1'b1;
        n    = (p == 16'h0000) ? 16'h0000 : 16'h0001;
      end else begin
        n = c - 16'h0001;
      end
    end
    return {nu, roll, n};
  endfunction

  // output level: start level set means high while count is below duty
  function automatic logic fcbp_wave(input logic [15:0] c, input logic [15:0] d, input logic start_hi);
    return start_hi ? (c < d) : !(c < d);
  endfunction

  // apb decode; write takes effect in the access phase, slave never stalls
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign pready = 1'b1;

  for (genvar i = 0; i < 4; i++) begin : g_dec
    assign wr_cnt[i]  = wr && fcbp_hit(paddr, `FCBP_OFF_CNT0, i);
    assign wr_per[i]  = wr && fcbp_hit(paddr, `FCBP_OFF_PER0, i);
    assign wr_duty[i] = wr && fcbp_hit(paddr, `FCBP_OFF_DUTY0, i);
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_hit   = 1'b1;
    case (paddr[7:0])
      `FCBP_OFF_CTRL:     next_rdata = {18'h00000, ctrl};
      `FCBP_OFF_CLKSEL:   next_rdata = {22'h000000, clksel};
      `FCBP_OFF_SCALE0:   next_rdata = {24'h000000, scale[0]};
      `FCBP_OFF_SCALE1:   next_rdata = {24'h000000, scale[1]};
      `FCBP_OFF_GPIO_OUT: next_rdata = {28'h0000000, gpio_out};
      `FCBP_OFF_GPIO_DIR: next_rdata = {28'h0000000, gpio_dir};
      `FCBP_OFF_PIN_IN:   next_rdata = {28'h0000000, port_in};
      default:            next_hit   = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (fcbp_hit(paddr, `FCBP_OFF_CNT0, i)) begin
        next_rdata = {24'h000000, cnt[i]};
        next_hit   = 1'b1;
      end
      if (fcbp_hit(paddr, `FCBP_OFF_PER0, i)) begin
        next_rdata = {24'h000000, per_buf[i]};
        next_hit   = 1'b1;
      end
      if (fcbp_hit(paddr, `FCBP_OFF_DUTY0, i)) begin
        next_rdata = {24'h000000, duty_buf[i]};
        next_hit   = 1'b1;
      end
    end
  end

  // read data captured in the setup cycle so prdata comes from flops with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      hit_q  <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      hit_q  <= next_hit;
    end
  end

  assign pslverr = psel && penable && !hit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `FCBP_RST_CTRL;
      clksel   <= `FCBP_RST_CLKSEL;
      gpio_out <= `FCBP_RST_NIBBLE;
      gpio_dir <= `FCBP_RST_NIBBLE;
    end else if (wr) begin
      if (paddr[7:0] == `FCBP_OFF_CTRL)     ctrl     <= pwdata[`FCBP_CTRL_W-1:0];
      if (paddr[7:0] == `FCBP_OFF_CLKSEL)   clksel   <= pwdata[`FCBP_CLKSEL_W-1:0];
      if (paddr[7:0] == `FCBP_OFF_GPIO_OUT) gpio_out <= pwdata[3:0];
      if (paddr[7:0] == `FCBP_OFF_GPIO_DIR) gpio_dir <= pwdata[3:0];
    end
  end

  // prescaler stops while every channel is off to save power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres <= '0;
    end else if (|ctrl.channel_output_enable) begin
      pres <= pres + PRES_W'(1);
    end
  end

  // clock a feeds pair 0 and scaler 0, clock b feeds pair 1 and scaler 1
  for (genvar k = 0; k < 2; k++) begin : g_clk
    logic [2:0]        sel_div;
    logic [PRES_W-1:0] mask;
    logic              wr_scale;
    assign sel_div  = (k == 0) ? clksel.prescale_a : clksel.prescale_b;
    assign mask     = PRES_W'((8'h01 << sel_div) - 8'h01);
    assign ab_tick[k] = (|ctrl.channel_output_enable) && (&(pres | ~mask));
    assign wr_scale = wr && (paddr[7:0] == ((k == 0) ? `FCBP_OFF_SCALE0 : `FCBP_OFF_SCALE1));
    assign s_tick[k] = ab_tick[k] && (scale_cnt[k] == 8'h00) && scale_half[k];

    // scaled clock divides by (scale + 1) and again by two
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scale[k]      <= `FCBP_RST_BYTE;
        scale_cnt[k]  <= `FCBP_RST_BYTE;
        scale_half[k] <= 1'b0;
      end else if (wr_scale) begin
        scale[k]      <= pwdata[7:0];
        scale_cnt[k]  <= pwdata[7:0];
        scale_half[k] <= 1'b0;
      end else if (ab_tick[k]) begin
        if (scale_cnt[k] == 8'h00) begin
          scale_cnt[k]  <= scale[k];
          scale_half[k] <= !scale_half[k];
        end else begin
          scale_cnt[k] <= scale_cnt[k] - 8'h01;
        end
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_tick
    assign ch_tick[i] = clksel.scaled_select[i] ? s_tick[i/2] : ab_tick[i/2];
  end

  // each pair runs as two 8-bit engines or one 16-bit engine
  for (genvar p = 0; p < 2; p++) begin : g_pair
    localparam int H = 2 * p;
    localparam int L = 2 * p + 1;
    logic        jn;
    logic [15:0] c_h;
    logic [15:0] c_l;
    logic [15:0] p_h;
    logic [15:0] p_l;
    logic [15:0] d_h;
    logic [15:0] d_l;
    logic [17:0] s_h;
    logic [17:0] s_l;
    logic [15:0] n_h;
    logic [15:0] n_l;
    logic        run_h;
    logic        run_l;
    logic        tk_h;
    logic        cwr_h;
    logic        cwr_l;
    logic        roll_h;
    logic        roll_l;

    assign jn  = (p == 0) ? ctrl.join_pair_low : ctrl.join_pair_high;
    assign c_h = jn ? {cnt[H], cnt[L]} : {8'h00, cnt[H]};
    assign p_h = jn ? {per_act[H], per_act[L]} : {8'h00, per_act[H]};
    assign d_h = jn ? {duty_act[H], duty_act[L]} : {8'h00, duty_act[H]};
    assign c_l = {8'h00, cnt[L]};
    assign p_l = {8'h00, per_act[L]};
    assign d_l = {8'h00, duty_act[L]};

    // joined pair runs on the low-byte channel clock, enabled by the high-byte channel
    assign run_h = ctrl.channel_output_enable[H];
    assign run_l = jn ? run_h : ctrl.channel_output_enable[L];
    assign tk_h  = jn ? ch_tick[L] : ch_tick[H];
    assign cwr_h = wr_cnt[H] || (jn && wr_cnt[L]);
    assign cwr_l = wr_cnt[L] || (jn && wr_cnt[H]);

    assign s_h = fcbp_step(c_h, p_h, ctrl.center_align[H], count_up[H]);
    assign s_l = fcbp_step(c_l, p_l, ctrl.center_align[L], count_up[L]);

    // disabled counters hold their value
    assign n_h    = cwr_h ? 16'h0000 : ((run_h && tk_h) ? s_h[15:0] : c_h);
    assign n_l    = cwr_l ? 16'h0000 : ((run_l && ch_tick[L]) ? s_l[15:0] : c_l);
    assign roll_h = run_h && tk_h && s_h[16] && !cwr_h;
    assign roll_l = run_l && ch_tick[L] && s_l[16] && !cwr_l;

    assign next_cnt[H] = jn ? n_h[15:8] : n_h[7:0];
    assign next_cnt[L] = jn ? n_h[7:0] : n_l[7:0];
    assign next_up[H]  = cwr_h ? 1'b1 : ((run_h && tk_h) ? s_h[17] : count_up[H]);
    assign next_up[L]  = jn ? next_up[H] : (cwr_l ? 1'b1 : ((run_l && ch_tick[L]) ? s_l[17] : count_up[L]));

    // active latches follow the buffer when off, else only on rollover or counter write
    assign load_act[H] = !run_h || cwr_h || roll_h;
    assign load_act[L] = jn ? load_act[H] : (!run_l || cwr_l || roll_l);

    assign next_armed[H] = run_h && (armed[H] || tk_h);
    assign next_armed[L] = run_l && (armed[L] || ch_tick[L]);

    assign pin_own[H]  = run_h;
    assign pin_own[L]  = !jn && run_l;
    assign pin_wave[H] = armed[H] && fcbp_wave(c_h, d_h, ctrl.channel_start_level_select[H]);
    assign pin_wave[L] = armed[L] && fcbp_wave(c_l, d_l, ctrl.channel_start_level_select[L]);
  end

  // per-channel storage: buffers, active latches, counter, direction
  for (genvar i = 0; i < 4; i++) begin : g_ch
    assign next_per[i]  = wr_per[i] ? pwdata[7:0] : per_buf[i];
    assign next_duty[i] = wr_duty[i] ? pwdata[7:0] : duty_buf[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        per_buf[i]  <= `FCBP_RST_PERIOD;
        duty_buf[i] <= `FCBP_RST_BYTE;
      end else begin
        per_buf[i]  <= next_per[i];
        duty_buf[i] <= next_duty[i];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        per_act[i]  <= `FCBP_RST_PERIOD;
        duty_act[i] <= `FCBP_RST_BYTE;
      end else if (load_act[i]) begin
        per_act[i]  <= next_per[i];
        duty_act[i] <= next_duty[i];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[i]      <= `FCBP_RST_BYTE;
        count_up[i] <= 1'b1;
        armed[i]    <= 1'b0;
      end else begin
        cnt[i]      <= next_cnt[i];
        count_up[i] <= next_up[i];
        armed[i]    <= next_armed[i];
      end
    end
  end

  // enabled channels, except the upper channel of a joined pair, force the pin to output without touching the direction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_drive <= '0;
    end else begin
      port_drive.enable <= pin_own | gpio_dir;
      port_drive.data   <= (pin_own & pin_wave) | (~pin_own & gpio_out);
    end
  end

endmodule

// [shared/fcbp_map.svh]
// register offsets, register widths and reset values of the four-channel pwm
`ifndef FCBP_MAP_SVH
`define FCBP_MAP_SVH
`define FCBP_OFF_CTRL      8'h00
`define FCBP_OFF_CLKSEL    8'h04
`define FCBP_OFF_SCALE0    8'h08
`define FCBP_OFF_SCALE1    8'h0c
`define FCBP_OFF_CNT0      8'h10
`define FCBP_OFF_PER0      8'h20
`define FCBP_OFF_DUTY0     8'h30
`define FCBP_OFF_GPIO_OUT  8'h40
`define FCBP_OFF_GPIO_DIR  8'h44
`define FCBP_OFF_PIN_IN    8'h48
`define FCBP_CH_STRIDE     8'h04
`define FCBP_CTRL_W        14
`define FCBP_CLKSEL_W      10
`define FCBP_RST_CTRL      14'h0000
`define FCBP_RST_CLKSEL    10'h000
`define FCBP_RST_BYTE      8'h00
`define FCBP_RST_PERIOD    8'hff
`define FCBP_RST_NIBBLE    4'h0
`endif

// [shared/fcbp_pkg.sv]
// types shared by the four-channel pwm design
package fcbp_pkg;
  // control word: enables [3:0], start levels [7:4], center align [11:8], joins [13:12]
  typedef struct packed {
    logic       join_pair_high;
    logic       join_pair_low;
    logic [3:0] center_align;
    logic [3:0] channel_start_level_select;
    logic [3:0] channel_output_enable;
  } fcbp_ctrl_t;

  // clock word: per-channel scaled select [3:0], prescale a [6:4], prescale b [9:7]
  typedef struct packed {
    logic [2:0] prescale_b;
    logic [2:0] prescale_a;
    logic [3:0] scaled_select;
  } fcbp_clksel_t;

  typedef struct packed {
    logic [3:0] data;
    logic [3:0] enable;
  } fcbp_pins_t;
endpackage

// [sim/fcbp_checker.sv]
// assertion checker on the pwm top-level ports
module fcbp_checker
  import fcbp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PRES_W = 7
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        port_in,
  input wire fcbp_pins_t        port_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] ctl;
  logic        live;
  logic [3:0]  gout;
  logic [3:0]  gdir;
  logic [3:0]  pwm;
  wire logic   acc = psel && penable;
  // shadow of the registers that decide pin ownership and port data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl  <= '0;
      gout <= '0;
      gdir <= '0;
    end else if (acc && pwrite) begin
      if (paddr == 8'h00) ctl <= pwdata[13:0];
      if (paddr == 8'h40) gout <= pwdata[3:0];
      if (paddr == 8'h44) gdir <= pwdata[3:0];
    end
  end
  // a joined pair leaves the upper pin to the port
  assign pwm = {ctl[3] & ~ctl[13], ctl[2], ctl[1] & ~ctl[12], ctl[0]};
  // checks wait one edge past reset so a past value never reaches the state before reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live <= 1'b0;
    end else begin
      live <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !live);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr >= 8'h4c |-> pslverr) else $error("no error");
  a_mapped_ok: assert property (acc && paddr <= 8'h48 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  a_err_access: assert property (!acc |-> !pslverr) else $error("error outside access");
  a_unmapped_zero: assert property (acc && !pwrite && paddr >= 8'h4c |-> prdata == 32'h0)
    else $error("unmapped data");
  a_rdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved");
  a_pin_owner: assert property (port_drive.enable == $past(pwm | gdir))
    else $error("pin enable wrong");
  a_gpio_level: assert property (((port_drive.data ^ $past(gout)) & $past(gdir & ~pwm)) == 4'h0)
    else $error("port data wrong");
  a_start_quiet: assert property ($rose(port_drive.enable[0]) && $past(pwm[0]) |-> !port_drive.data[0])
    else $error("output before tick");
  c_unmapped: cover property (acc && pslverr);
  c_pwm_on: cover property ($rose(port_drive.enable[0]));
  c_joined: cover property (ctl[12] && port_drive.enable[0]);
endmodule

bind fcbp_top fcbp_checker #(.ADDR_W(ADDR_W), .PRES_W(PRES_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_in(port_in), .port_drive(port_drive));

// [sim/fcbp_load.sv]
// external load on the shared port pins
module fcbp_load
  import fcbp_pkg::*;
(
  input wire logic       pclk,
  input wire fcbp_pins_t pins,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic     [3:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating pin wanders so a stale value never reads as valid
  logic [3:0] wander = 4'h5;
  always_ff @(posedge pclk) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level[i] = pins.enable[i] ? pins.data[i] : (ext_en[i] ? ext_val[i] : wander[i]);
    end
  end
endmodule

// [sim/four_channel_buffered_pwm_test.sv]
// self-checking bench for the four-channel pwm
module four_channel_buffered_pwm_test
  import fcbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  port_in, ext_en = 4'h3, ext_val = 4'h0;
  fcbp_pins_t  port_drive;
  int          fail_count = 0, num_checks = 0;
  initial forever #2 pclk = ~pclk;
  fcbp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_in(port_in), .port_drive(port_drive));
  fcbp_load u_load (.pclk(pclk), .pins(port_drive), .ext_en(ext_en), .ext_val(ext_val), .level(port_in));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fail_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // reference waveform: high cycles of pin 0 over 256 clocks
  function int model(int per, int duty, int lvl, int ctr, int div);
    int c, up, hi;
    c = 0; up = 1; hi = 0;
    for (int i = 0; i < 256; i++) begin
      if ((c < duty) == (lvl == 1)) hi++;
      if (i % div == div - 1) begin
        if (ctr == 0) c = (c + 1 >= per) ? 0 : c + 1;
        else if (up == 1) begin
          c++;
          if (c >= per) up = 0;
        end else begin
          c--;
          if (c == 0) up = 1;
        end
      end
    end
    return hi;
  endfunction
  task meas(input int exp);
    int h;
    h = 0;
    repeat (40) @(posedge pclk);
    repeat (256) begin
      @(posedge pclk);
      if (port_in[0] === 1'b1) h++;
    end
    chk("high_time", h, exp);
  endtask
  // scenario table: period, duty, control word, clock select, scaler and resulting tick divisor
  int          per[9]  = '{4, 4, 4, 4, 4, 4, 4, 8, 4};
  int          duty[9] = '{1, 1, 0, 4, 1, 1, 2, 2, 1};
  int          ctl[9]  = '{'h11, 'h01, 'h11, 'h11, 'h11, 'h11, 'h111, 'h1011, 'h11};
  int          clk[9]  = '{0, 0, 0, 0, 'h10, 'h01, 0, 0, 'h01};
  int          scl[9]  = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  int          div[9]  = '{1, 1, 1, 1, 2, 2, 1, 1, 4};
  logic [7:0]  ra[7]   = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30, 8'h44};
  logic [31:0] rv[7]   = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'h0, 32'h0};
  initial begin
    logic [31:0] c1;
    logic [3:0] gv;
    void'($urandom(32'h2842));
    duty[0] = $urandom_range(3, 1);
    gv = 4'($urandom());
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, ra[k], 32'h0);
      chk("reset_value", rd, rv[k]);
    end
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped_err", er, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, 8'h60, 32'hffff);
    chk("unmapped_werr", er, 32'h1);
    ext_val <= gv ^ 4'h5;
    apb(1'b1, 8'h40, {28'h0, gv});
    apb(1'b1, 8'h44, 32'hc);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h48, 32'h0);
    chk("pin_in", rd, {28'h0, gv[3:2], ext_val[1:0]});
    chk("pin_enable", port_drive.enable, 32'hc);
    for (int k = 0; k < 9; k++) begin
      // disabled channel: buffer writes reach the active latch at once
      apb(1'b1, 8'h20, ctl[k][12] ? 0 : per[k]);
      apb(1'b1, 8'h30, ctl[k][12] ? 0 : duty[k]);
      if (ctl[k][12]) begin
        apb(1'b1, 8'h24, per[k]);
        apb(1'b1, 8'h34, duty[k]);
      end
      apb(1'b1, 8'h04, clk[k]);
      apb(1'b1, 8'h08, scl[k]);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h00, ctl[k]);
      meas(model(per[k], duty[k], ctl[k][4], ctl[k][8], div[k]));
      apb(1'b1, 8'h00, 32'h0);
    end
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h20, 32'h4);
    apb(1'b1, 8'h30, 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h11);
    repeat (20) @(posedge pclk);
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h10, 32'h0);
    meas(model(4, 3, 1, 0, 1));
    apb(1'b1, 8'h04, 32'h70);
    apb(1'b1, 8'h20, 32'hc8);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    repeat (600) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    c1 = rd;
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk("count_held", rd, c1);
    chk("count_moved", c1 != 0, 32'h1);
    apb(1'b1, 8'h10, 32'h5);
    apb(1'b0, 8'h10, 32'h0);
    chk("count_cleared", rd, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk("period_after_reset", rd, 32'hff);
    report_and_stop();
  end
endmodule
